// [mux_timing_pkg.sv]
// Purpose: Shared constants and carriers for the stream timing checker
// Assumes: 100 MHz system clock, APB register access
// Notes: Time stamps arrive already parsed as event strobes
package mux_timing_pkg;
   localparam int unsigned clk_mhz = 100;
   localparam int unsigned lim_pack_ms = 700;
   localparam int unsigned lim_prog_ms = 100;
   localparam int unsigned lim_elem_ms = 700;
   localparam int unsigned lim_pres_ms = 700;
   localparam int unsigned cyc_pack = lim_pack_ms * 1000 * clk_mhz;
   localparam int unsigned cyc_prog = lim_prog_ms * 1000 * clk_mhz;
   localparam int unsigned cyc_elem = lim_elem_ms * 1000 * clk_mhz;
   localparam int unsigned cyc_pres = lim_pres_ms * 1000 * clk_mhz;
   localparam int unsigned min_refs_between_disc = 2;
   localparam logic [21:0] drain_unit_bps = 22'h000190;
   localparam logic [15:0] delay_none = 16'hffff;
   localparam logic [7:0] off_ctrl = 8'h00;
   localparam logic [7:0] off_status = 8'h04;
   localparam logic [7:0] off_smooth_rate = 8'h08;
   localparam logic [7:0] off_smooth_cap = 8'h0c;
   localparam logic [7:0] off_target = 8'h10;
   localparam logic [7:0] off_group = 8'h14;
   localparam logic [31:0] ctrl_reset_val = 32'h0000_0000;
   localparam logic [13:0] group_len_reset_val = 14'h0001;
   localparam int unsigned n_viol = 14;

   typedef enum logic [3:0] {
      v_pack, v_prog, v_prog_few, v_elem, v_pes_noelem, v_pres, v_first_pres, v_disc_place,
      v_disc_pres, v_underflow_pres, v_pres_place, v_decode_stamp, v_zero_group, v_group_shape
   } viol_t;

   // One parsed event from the stream front end
   typedef struct packed {
      logic pack_ref;
      logic prog_ref;
      logic prog_disc;
      logic elem_ref;
      logic au_start;
      logic pres_present;
      logic decode_present;
      logic times_differ;
      logic start_in_packet;
      logic seq_start;
      logic underflow;
      logic late_decode;
      logic intra_pic;
      logic group_hdr;
      logic group_closed;
   } stream_evt_t;

   typedef struct packed {
      logic [21:0] drain_rate;
      logic [21:0] capacity;
   } smooth_cfg_t;
endpackage : mux_timing_pkg

// [mux_stream_timing_checker.sv]
// Purpose: Checks time-reference and time-stamp placement in a multiplex
// Assumes: Upstream parser gives one-cycle strobes per stream event
// Notes: One stream watched at a time; violations sticky until cleared
//
// What this block does
// - Pack clock refs at most 0,7 s apart
// - Program clock refs at most 0,1 s apart
// - Two program refs between discontinuities
// - Elementary refs, when present, within 0,7 s
// - Bare elementary stream requires elementary refs
// - Presentation stamps at most 0,7 s apart
// - Still pictures skip stamp interval check
// - First access unit carries presentation stamp
// - Late decode time marks a discontinuity
// - Video discontinuity only at sequence start, outside trick and low delay
// - Stamp required with each discontinuity outside trick mode
// - Low delay: stamp after buffer underflow
// - Stamp only with picture/audio unit start
// - Decoding stamp iff stamp and times differ
// - Drain rate is field times 400
// - Smoothing capacity counted in bytes
// - Leak flag selects transfer method
// - Target descriptor only transport video
// - Closed-group flag: closed header before intra
// - Identical-group flag: repeating picture pattern
// - Maximum group length never zero
`timescale 1ns/1ns
module mux_stream_timing_checker (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [7:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   input wire mux_timing_pkg::stream_evt_t i_evt,
   input wire logic i_delay_is_none,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   output logic o_violation,
   output logic o_leak_method,
   output logic o_delay_method,
   output logic [31:0] o_drain_bps
);
   import mux_timing_pkg::*;

   // Control: [0] transport, [1] video, [2] still, [3] bare pes, [4] trick, [5] low delay
   logic [31:0] ctrl_q, ctrl_d;
   logic [13:0] viol_q, viol_d;
   logic viol_any_q, viol_any_d;
   smooth_cfg_t smooth_q, smooth_d;
   logic leak_flag_q, leak_flag_d;
   logic closed_flag_q, closed_flag_d, ident_flag_q, ident_flag_d;
   logic [13:0] max_group_q, max_group_d;
   logic [31:0] prdata_q, prdata_d;
   logic pready_q, pready_d, pslverr_q, pslverr_d;
   logic [31:0] pack_cnt_q, pack_cnt_d, prog_cnt_q, prog_cnt_d;
   logic [31:0] elem_cnt_q, elem_cnt_d, pres_cnt_q, pres_cnt_d;
   logic pack_seen_q, pack_seen_d, prog_seen_q, prog_seen_d;
   logic elem_seen_q, elem_seen_d, pres_seen_q, pres_seen_d;
   logic [1:0] prog_since_q, prog_since_d;
   logic prog_disc_seen_q, prog_disc_seen_d;
   logic first_au_q, first_au_d, need_pres_q, need_pres_d;
   logic [13:0] pics_q, pics_d, last_len_q, last_len_d;
   logic [1:0] intra_seen_q, intra_seen_d;
   logic group_before_q, group_before_d;
   logic [31:0] drain_q, drain_d;
   logic leak_out_q, leak_out_d, delay_out_q, delay_out_d;

   logic is_ts, is_video, is_still, is_pes, trick, low_delay;
   logic wr, rd, disc;

   assign is_ts = ctrl_q[0];
   assign is_video = ctrl_q[1];
   assign is_still = ctrl_q[2];
   assign is_pes = ctrl_q[3];
   assign trick = ctrl_q[4];
   assign low_delay = ctrl_q[5];
   assign wr = i_psel && i_penable && i_pwrite && !pready_q;
   assign rd = i_psel && i_penable && !i_pwrite && !pready_q;
   assign disc = i_evt.au_start && i_evt.late_decode;

   always_comb begin
      ctrl_d = ctrl_q;
      smooth_d = smooth_q;
      leak_flag_d = leak_flag_q;
      closed_flag_d = closed_flag_q;
      ident_flag_d = ident_flag_q;
      max_group_d = max_group_q;
      prdata_d = prdata_q;
      pready_d = 1'b0;
      pslverr_d = 1'b0;
      // Access answered one cycle after it is taken
      if (i_psel && i_penable && !pready_q) begin
         pready_d = 1'b1;
         case (i_paddr)
            off_ctrl: prdata_d = ctrl_q;
            off_status: prdata_d = {18'h0, viol_q};
            off_smooth_rate: prdata_d = {10'h0, smooth_q.drain_rate};
            off_smooth_cap: prdata_d = {10'h0, smooth_q.capacity};
            off_target: prdata_d = {31'h0, leak_flag_q};
            off_group: prdata_d = {16'h0, closed_flag_q, ident_flag_q, max_group_q};
            default: begin
               prdata_d = 32'h0;
               pslverr_d = 1'b1;
            end
         endcase
         if (!rd) begin
            prdata_d = 32'h0;
         end
      end
      if (wr) begin
         case (i_paddr)
            off_ctrl: ctrl_d = i_pwdata;
            off_smooth_rate: smooth_d.drain_rate = i_pwdata[21:0];
            off_smooth_cap: smooth_d.capacity = i_pwdata[21:0];
            off_target: leak_flag_d = i_pwdata[0];
            off_group: begin
               closed_flag_d = i_pwdata[15];
               ident_flag_d = i_pwdata[14];
               max_group_d = i_pwdata[13:0];
            end
            default: ctrl_d = ctrl_q;
         endcase
      end
   end

   always_comb begin
      logic [13:0] set;
      set = 14'h0;
      // Counters stop at the limit, so a gap of any length still reads as too long
      pack_cnt_d = !pack_seen_q ? 32'h0 : (pack_cnt_q >= cyc_pack) ? pack_cnt_q : pack_cnt_q + 32'h1;
      prog_cnt_d = !prog_seen_q ? 32'h0 : (prog_cnt_q >= cyc_prog) ? prog_cnt_q : prog_cnt_q + 32'h1;
      elem_cnt_d = !elem_seen_q ? 32'h0 : (elem_cnt_q >= cyc_elem) ? elem_cnt_q : elem_cnt_q + 32'h1;
      pres_cnt_d = !pres_seen_q ? 32'h0 : (pres_cnt_q >= cyc_pres) ? pres_cnt_q : pres_cnt_q + 32'h1;
      pack_seen_d = pack_seen_q;
      prog_seen_d = prog_seen_q;
      elem_seen_d = elem_seen_q;
      pres_seen_d = pres_seen_q;
      prog_since_d = prog_since_q;
      prog_disc_seen_d = prog_disc_seen_q;
      first_au_d = first_au_q;
      need_pres_d = need_pres_q;
      pics_d = pics_q;
      last_len_d = last_len_q;
      intra_seen_d = intra_seen_q;
      group_before_d = group_before_q;
      if (i_evt.pack_ref) begin
         if (pack_seen_q && pack_cnt_q >= cyc_pack) set[v_pack] = 1'b1;
         pack_seen_d = 1'b1;
         pack_cnt_d = 32'h0;
      end
      if (i_evt.prog_ref) begin
         if (prog_seen_q && prog_cnt_q >= cyc_prog) set[v_prog] = 1'b1;
         prog_seen_d = 1'b1;
         prog_cnt_d = 32'h0;
         if (prog_since_q != 2'h3) prog_since_d = prog_since_q + 2'h1;
      end
      if (i_evt.prog_disc) begin
         if (prog_disc_seen_q && 32'(prog_since_q) < min_refs_between_disc) set[v_prog_few] = 1'b1;
         prog_disc_seen_d = 1'b1;
         prog_since_d = 2'h0;
         prog_seen_d = 1'b0;
      end
      if (i_evt.elem_ref) begin
         if (elem_seen_q && elem_cnt_q >= cyc_elem) set[v_elem] = 1'b1;
         elem_seen_d = 1'b1;
         elem_cnt_d = 32'h0;
      end
      // Bare stream: refs expected from the second unit on
      if (is_pes && !elem_seen_q && first_au_q == 1'b0 && i_evt.au_start) set[v_pes_noelem] = 1'b1;
      if (is_pes && elem_seen_q && elem_cnt_q >= cyc_elem) set[v_pes_noelem] = 1'b1;
      // Discontinuity restarts the stamp interval
      if (disc) begin
         pres_seen_d = 1'b0;
         if (is_video && !i_evt.seq_start && !trick && !low_delay) set[v_disc_place] = 1'b1;
      end
      if (i_evt.au_start) begin
         if (first_au_q && !i_evt.pres_present) set[v_first_pres] = 1'b1;
         if ((disc && !trick) || need_pres_q) begin
            if (!i_evt.pres_present) set[need_pres_q ? v_underflow_pres : v_disc_pres] = 1'b1;
         end
         first_au_d = 1'b0;
         need_pres_d = 1'b0;
      end
      if (i_evt.underflow && low_delay) need_pres_d = 1'b1;
      if (i_evt.pres_present) begin
         if (pres_seen_q && !disc && !is_still && pres_cnt_q >= cyc_pres) set[v_pres] = 1'b1;
         if (!i_evt.start_in_packet) set[v_pres_place] = 1'b1;
         pres_seen_d = 1'b1;
         pres_cnt_d = 32'h0;
      end
      if (i_evt.decode_present != (i_evt.pres_present && i_evt.times_differ)) set[v_decode_stamp] = 1'b1;
      if (max_group_q == 14'h0 && is_video) set[v_zero_group] = 1'b1;
      // Picture-group tracking, video only except the group-header latch, which runs in any mode
      if (i_evt.group_hdr) group_before_d = 1'b1;
      if (i_evt.au_start && is_video) begin
         if (i_evt.intra_pic) begin
            if (closed_flag_q && !(group_before_q && i_evt.group_closed)) set[v_group_shape] = 1'b1;
            if (ident_flag_q && intra_seen_q == 2'h2 && pics_q != last_len_q) set[v_group_shape] = 1'b1;
            if (pics_q > max_group_q && intra_seen_q != 2'h0) set[v_group_shape] = 1'b1;
            if (intra_seen_q != 2'h0) last_len_d = pics_q;
            if (intra_seen_q != 2'h2) intra_seen_d = intra_seen_q + 2'h1;
            pics_d = 14'h0;
            group_before_d = 1'b0;
         end else if (pics_q != 14'h3fff) begin
            pics_d = pics_q + 14'h1;
         end
      end
      viol_d = viol_q | set;
      if (wr && i_paddr == off_status) viol_d = (viol_q & ~i_pwdata[13:0]) | set;
      viol_any_d = |viol_d;
      drain_d = 32'({10'h0, smooth_q.drain_rate} * {10'h0, drain_unit_bps});
      leak_out_d = leak_flag_q && is_ts && is_video;
      delay_out_d = !leak_flag_q && !i_delay_is_none && is_ts && is_video;
   end

   // Register bus state
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         ctrl_q <= ctrl_reset_val;
         smooth_q <= '0;
         leak_flag_q <= 1'b0;
         closed_flag_q <= 1'b0;
         ident_flag_q <= 1'b0;
         max_group_q <= group_len_reset_val;
         prdata_q <= 32'h0;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
      end else begin
         ctrl_q <= ctrl_d;
         smooth_q <= smooth_d;
         leak_flag_q <= leak_flag_d;
         closed_flag_q <= closed_flag_d;
         ident_flag_q <= ident_flag_d;
         max_group_q <= max_group_d;
         prdata_q <= prdata_d;
         pready_q <= pready_d;
         pslverr_q <= pslverr_d;
      end
   end

   // Monitor state: interval counters, sequence trackers, sticky flags
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         viol_q <= 14'h0;
         viol_any_q <= 1'b0;
         pack_cnt_q <= 32'h0;
         prog_cnt_q <= 32'h0;
         elem_cnt_q <= 32'h0;
         pres_cnt_q <= 32'h0;
         pack_seen_q <= 1'b0;
         prog_seen_q <= 1'b0;
         elem_seen_q <= 1'b0;
         pres_seen_q <= 1'b0;
         prog_since_q <= 2'h0;
         prog_disc_seen_q <= 1'b0;
         first_au_q <= 1'b1;
         need_pres_q <= 1'b0;
         pics_q <= 14'h0;
         last_len_q <= 14'h0;
         intra_seen_q <= 2'h0;
         group_before_q <= 1'b0;
         drain_q <= 32'h0;
         leak_out_q <= 1'b0;
         delay_out_q <= 1'b0;
      end else begin
         viol_q <= viol_d;
         viol_any_q <= viol_any_d;
         pack_cnt_q <= pack_cnt_d;
         prog_cnt_q <= prog_cnt_d;
         elem_cnt_q <= elem_cnt_d;
         pres_cnt_q <= pres_cnt_d;
         pack_seen_q <= pack_seen_d;
         prog_seen_q <= prog_seen_d;
         elem_seen_q <= elem_seen_d;
         pres_seen_q <= pres_seen_d;
         prog_since_q <= prog_since_d;
         prog_disc_seen_q <= prog_disc_seen_d;
         first_au_q <= first_au_d;
         need_pres_q <= need_pres_d;
         pics_q <= pics_d;
         last_len_q <= last_len_d;
         intra_seen_q <= intra_seen_d;
         group_before_q <= group_before_d;
         drain_q <= drain_d;
         leak_out_q <= leak_out_d;
         delay_out_q <= delay_out_d;
      end
   end

   assign o_prdata = prdata_q;
   assign o_pready = pready_q;
   assign o_pslverr = pslverr_q;
   assign o_violation = viol_any_q;
   assign o_leak_method = leak_out_q;
   assign o_delay_method = delay_out_q;
   assign o_drain_bps = drain_q;

   // Interval checks
   a_pack_gap: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      i_evt.pack_ref && pack_seen_q && pack_cnt_q >= cyc_pack |=> viol_q[v_pack])
      else $error("pack gap not flagged");
   a_prog_gap: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      i_evt.prog_ref && prog_seen_q && prog_cnt_q >= cyc_prog |=> viol_q[v_prog])
      else $error("program ref gap not flagged");
   a_few_refs: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      i_evt.prog_disc && prog_disc_seen_q && 32'(prog_since_q) < min_refs_between_disc |=> viol_q[v_prog_few])
      else $error("too few program refs not flagged");
   a_elem_gap: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      i_evt.elem_ref && elem_seen_q && elem_cnt_q >= cyc_elem |=> viol_q[v_elem])
      else $error("elementary ref gap not flagged");
   a_pes_noelem: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      is_pes && !elem_seen_q && !first_au_q && i_evt.au_start |=> viol_q[v_pes_noelem])
      else $error("bare stream without refs not flagged");
   a_pres_gap: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      i_evt.pres_present && pres_seen_q && !disc && !is_still && pres_cnt_q >= cyc_pres |=> viol_q[v_pres])
      else $error("stamp gap not flagged");
   a_still_skip: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      is_still && !viol_q[v_pres] |=> !viol_q[v_pres])
      else $error("stamp gap flagged on still pictures");

   // Stamp placement checks
   a_first_stamp: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      first_au_q && i_evt.au_start && !i_evt.pres_present |=> viol_q[v_first_pres])
      else $error("missing first stamp not flagged");
   a_late_disc: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      disc && !i_evt.pres_present |=> !pres_seen_q)
      else $error("late decode did not restart stamp interval");
   a_disc_place: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      disc && is_video && !i_evt.seq_start && !trick && !low_delay |=> viol_q[v_disc_place])
      else $error("misplaced discontinuity not flagged");
   a_disc_stamp: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      disc && !trick && !need_pres_q && !i_evt.pres_present |=> viol_q[v_disc_pres])
      else $error("missing stamp after discontinuity not flagged");
   a_under_stamp: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      need_pres_q && i_evt.au_start && !i_evt.pres_present |=> viol_q[v_underflow_pres])
      else $error("missing stamp after underflow not flagged");
   a_stamp_place: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      i_evt.pres_present && !i_evt.start_in_packet |=> viol_q[v_pres_place])
      else $error("misplaced stamp not flagged");
   a_decode_pair: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      i_evt.decode_present && !i_evt.pres_present |=> viol_q[v_decode_stamp])
      else $error("lone decoding stamp not flagged");
   a_decode_need: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      i_evt.pres_present && i_evt.times_differ && !i_evt.decode_present |=> viol_q[v_decode_stamp])
      else $error("missing decoding stamp not flagged");

   // Descriptor decode and flag checks
   a_drain_scale: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      ##1 o_drain_bps == 32'($past(smooth_q.drain_rate)) * 32'd400)
      else $error("drain rate scaling wrong");
   a_method_excl: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      !(o_leak_method && o_delay_method) && (!o_leak_method || $past(is_ts && is_video)))
      else $error("transfer method selection wrong");
   a_method_delay: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      o_delay_method |-> $past(!leak_flag_q && !i_delay_is_none && is_ts && is_video))
      else $error("delay method selected wrongly");
   a_closed_group: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      i_evt.au_start && is_video && i_evt.intra_pic && closed_flag_q && !group_before_q |=> viol_q[v_group_shape])
      else $error("intra picture without group header not flagged");
   a_ident_group: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      i_evt.au_start && is_video && i_evt.intra_pic && ident_flag_q && intra_seen_q == 2'h2 && pics_q != last_len_q
      |=> viol_q[v_group_shape])
      else $error("changed group pattern not flagged");
   a_zero_group: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      max_group_q == 14'h0 && is_video |=> viol_q[v_zero_group])
      else $error("zero group length not flagged");
   a_sticky_hold: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      !(wr && i_paddr == off_status) |=> (viol_q & $past(viol_q)) == $past(viol_q))
      else $error("violation flag not sticky");
   a_viol_out: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      o_violation == (|viol_q))
      else $error("violation output disagrees with flags");

   // Coverage of the main scenarios
   c_pack_viol: cover property (@(posedge i_clk) disable iff (!i_rst_n) $rose(viol_q[v_pack]));
   c_disc: cover property (@(posedge i_clk) disable iff (!i_rst_n) disc ##1 i_evt.au_start);
   c_intra: cover property (@(posedge i_clk) disable iff (!i_rst_n) i_evt.intra_pic && intra_seen_q == 2'h2);
   c_read: cover property (@(posedge i_clk) disable iff (!i_rst_n) rd && i_paddr == off_status);
   c_underflow: cover property (@(posedge i_clk) disable iff (!i_rst_n) need_pres_q && i_evt.au_start);
endmodule : mux_stream_timing_checker

// [mux_source.sv]
// Purpose: Stream producer model driving parsed event strobes
// Assumes: Bench asks for one event at a time
// Notes: Stamp coding is made legal only on unit starts while i_bad is low
`timescale 1ns/1ns
module mux_source (
   input wire logic i_clk,
   input wire logic i_send,
   input wire logic i_bad,
   input wire mux_timing_pkg::stream_evt_t i_req,
   output mux_timing_pkg::stream_evt_t o_evt
);
   import mux_timing_pkg::*;
   stream_evt_t legal;
   always_comb begin
      legal = i_req;
      if (!i_bad && i_req.au_start) begin
         legal.decode_present = i_req.pres_present & i_req.times_differ;
         legal.start_in_packet = i_req.start_in_packet | i_req.pres_present;
      end
   end
   always_ff @(posedge i_clk) begin
      // One-cycle strobe, all low when idle
      o_evt <= i_send ? legal : '0;
   end
endmodule : mux_source

// [mux_stream_timing_checker_bench.sv]
// Purpose: Self-checking bench for the stream timing checker
// Assumes: Interval limits too long to reach; placement rules exercised
// Notes: Status is read and cleared after each event scenario
`timescale 1ns/1ns
module mux_stream_timing_checker_bench;
   import mux_timing_pkg::*;
   logic i_clk = 0, i_rst_n = 0, psel = 0, penable = 0, pwrite = 0, send = 0, bad = 0, dnone = 0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, drain, rd, o_drain_bps;
   logic pready, pslverr, viol, leak_m, delay_m, err;
   stream_evt_t req = '0, evt, e;
   int n_errors = 0, check_count = 0, cyc = 0, seed = 44;
   always #5 i_clk = ~i_clk;
   mux_source i_src (.i_clk(i_clk), .i_send(send), .i_bad(bad), .i_req(req), .o_evt(evt));
   mux_stream_timing_checker i_dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_psel(psel), .i_penable(penable),
      .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .i_evt(evt), .i_delay_is_none(dnone),
      .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .o_violation(viol),
      .o_leak_method(leak_m), .o_delay_method(delay_m), .o_drain_bps(o_drain_bps));
   task test_done;
      $display("checks %0d mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : test_done
   always @(posedge i_clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_errors++;
         test_done();
      end
   end
   task check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge i_clk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge i_clk);
      penable <= 1;
      do @(posedge i_clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
   endtask : apb
   task send_evt(input stream_evt_t x, input logic b);
      @(posedge i_clk);
      req <= x;
      bad <= b;
      send <= 1;
      @(posedge i_clk);
      send <= 0;
   endtask : send_evt
   task stat(input logic [13:0] exp, input string name);
      repeat (3) @(posedge i_clk);
      apb(0, off_status, 0);
      check(rd, {18'h0, exp});
      check(viol, |exp);
      apb(1, off_status, 32'h3fff);
      $display("test %s done", name);
   endtask : stat
   function automatic stream_evt_t au(logic p, logic sip, logic dec, logic dif);
      stream_evt_t x;
      x = '0;
      x.au_start = 1;
      x.pres_present = p;
      x.start_in_packet = sip;
      x.decode_present = dec;
      x.times_differ = dif;
      return x;
   endfunction : au
   initial begin
      repeat (20) @(posedge i_clk);
      i_rst_n <= 1;
      for (int i = 0; i < 6; i++) begin
         apb(0, 8'(i * 4), 0);
         check(rd, (i == 5) ? 32'(group_len_reset_val) : 32'h0);
      end
      apb(0, 8'h18, 0);
      check(err, 1);
      check(rd, 0);
      $display("test reset values done");
      for (int i = 0; i < 5; i++) begin
         drain = (i == 0) ? 32'h3fffff : $random(seed) & 32'h3fffff;
         apb(1, off_smooth_rate, drain);
         @(posedge i_clk);
         check(o_drain_bps, drain * 400);
         apb(1, off_smooth_cap, drain ^ 32'h2aaaaa);
         apb(0, off_smooth_cap, 0);
         check(rd, drain ^ 32'h2aaaaa);
      end
      $display("test smoothing done");
      for (int i = 0; i < 12; i++) begin
         dnone <= i[0];
         apb(1, off_ctrl, (i >> 2) + 1);
         apb(1, off_target, i[1]);
         repeat (2) @(posedge i_clk);
         check(leak_m, (i >> 2) == 2 && i[1]);
         check(delay_m, (i >> 2) == 2 && !i[1] && !i[0]);
      end
      $display("test transfer method done");
      apb(1, off_ctrl, 2);
      apb(1, off_group, 0);
      stat(14'h1000, "zero group");
      apb(1, off_group, 32'h5);
      apb(1, off_ctrl, 3);
      apb(1, off_status, 32'h3fff);
      send_evt(au(0, 0, 0, 0), 0);
      stat(14'h0040, "first unit");
      send_evt(au(1, 0, 0, 0), 1);
      stat(14'h0400, "stamp place");
      send_evt(au(1, 1, 1, 0), 1);
      send_evt(au(1, 1, 0, 1), 1);
      send_evt(au(0, 0, 1, 1), 1);
      stat(14'h0800, "decode stamp");
      send_evt(au(1, 1, 0, 1), 0);
      stat(14'h0000, "legal stamps");
      for (int i = 0; i < 4; i++) begin
         apb(1, off_ctrl, i[1] ? 32'h13 : 32'h3);
         e = au(i[0], i[0], 0, 0);
         e.late_decode = 1;
         e.seq_start = !i[0];
         send_evt(e, 0);
         send_evt(au(i[0], i[0], 0, 0), 0);
         stat((i == 1) ? 14'h0080 : (i == 0) ? 14'h0100 : 14'h0, "discontinuity");
      end
      for (int i = 0; i < 2; i++) begin
         apb(1, off_ctrl, i[0] ? 32'h23 : 32'h3);
         e = '0;
         e.underflow = 1;
         send_evt(e, 0);
         send_evt(au(0, 0, 0, 0), 0);
         stat(i[0] ? 14'h0200 : 14'h0, "underflow");
      end
      apb(1, off_ctrl, 1);
      e = '0;
      e.prog_disc = 1;
      send_evt(e, 0);
      apb(1, off_status, 32'h3fff);
      for (int i = 2; i > 0; i--) begin
         e = '0;
         e.prog_ref = 1;
         repeat (i) send_evt(e, 0);
         e = '0;
         e.prog_disc = 1;
         send_evt(e, 0);
         stat((i == 1) ? 14'h0004 : 14'h0, "program refs");
      end
      apb(1, off_ctrl, 3);
      apb(1, off_group, 32'h8005);
      e = '0;
      e.group_hdr = 1;
      e.group_closed = 1;
      send_evt(e, 0);
      e = au(1, 1, 0, 0);
      e.intra_pic = 1;
      e.group_closed = 1;
      send_evt(e, 0);
      stat(14'h0, "closed group");
      send_evt(e, 0);
      stat(14'h2000, "open group");
      test_done();
   end
endmodule : mux_stream_timing_checker_bench
